// File: rtl/sbr_pkg.sv
// constants, register map and state type for the brake release sequencer
`default_nettype none
package sbr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TICK_MS = 1;
  localparam int CYCLES_PER_MS = MS_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PARAM_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int GROUP_LSB = 5;
  localparam logic [2:0] GRP_MONITOR = 3'h0;
  localparam logic [2:0] GRP_BASIC = 3'h1;
  localparam logic [2:0] GRP_EXTENSION = 3'h2;
  localparam logic [2:0] GRP_COMM = 3'h3;
  localparam logic [2:0] GRP_DIAG = 3'h4;
  localparam logic [4:0] IDX_STATUS = 5'h00;
  localparam logic [4:0] IDX_RESTART_ACT = 5'h01;
  localparam logic [4:0] IDX_RELEASE_DLY = 5'h00;
  localparam logic [4:0] IDX_ENGAGE_DLY = 5'h01;
  localparam logic [4:0] IDX_ZERO_SPEED = 5'h02;
  localparam logic [4:0] IDX_LOCK_CFG = 5'h00;
  localparam logic [4:0] IDX_RESTART_PEND = 5'h01;
  localparam logic [4:0] IDX_VOLATILE = 5'h00;
  localparam logic [4:0] IDX_CONTROL = 5'h00;
  localparam logic [4:0] IDX_SPEED = 5'h01;
  localparam logic [4:0] IDX_REFUSED = 5'h02;
  localparam logic [15:0] RST_RELEASE_DLY = 16'h0000;
  localparam logic [15:0] RST_ENGAGE_DLY = 16'h0000;
  localparam logic [15:0] RST_ZERO_SPEED = 16'h000a;
  localparam logic [15:0] RST_LOCK_CFG = 16'h0001;
  localparam logic [15:0] RST_RESTART = 16'h0000;
  localparam logic [15:0] RST_VOLATILE = 16'h0000;
  localparam int ST_BRAKE_BIT = 0;
  localparam int ST_SERVO_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_STATE_LSB = 4;
  localparam int LOCK_SPEED_STOP_BIT = 0;
  localparam int CTRL_RESTART_BIT = 0;
  typedef enum logic [3:0]
  {
    ST_ENGAGED = 4'h1,
    ST_RELEASE_WAIT = 4'h2,
    ST_RELEASED = 4'h4,
    ST_ENGAGE_WAIT = 4'h8
  } sbr_state_type;
endpackage : sbr_pkg
`default_nettype wire

// File: rtl/sbr_timer_if.sv
// millisecond delay request and expiry between sequencer and timer
`timescale 1ns/1ps
`default_nettype none
interface sbr_timer_if;
  logic start;
  logic [sbr_pkg::PARAM_W-1:0] delayMs;
  logic expired;
  modport ctrl (output start, output delayMs, input expired);
  modport timer (input start, input delayMs, output expired);
endinterface : sbr_timer_if
`default_nettype wire

// File: rtl/sbr_sync3.sv
// three stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
`default_nettype none
module sbr_sync3
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic [2:0] stage_reg;
  logic level_reg;

  // only the second and third stage are compared; the first feeds nothing else
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end
    else
    begin
      stage_reg <= {stage_reg[1:0], asyncIn};
      if (stage_reg[2] == stage_reg[1])
      begin
        level_reg <= stage_reg[2];
      end
    end
  end

  assign syncOut = level_reg;
endmodule : sbr_sync3
`default_nettype wire

// File: rtl/sbr_ms_timer.sv
// millisecond delay counter, latches the delay at start
`timescale 1ns/1ps
`default_nettype none
module sbr_ms_timer #(
  parameter int CYCLES_PER_MS = sbr_pkg::CYCLES_PER_MS
)
(
  input wire logic core_clk,
  input wire logic rstn,
  sbr_timer_if.timer tmr
);
  localparam int CYC_W = $clog2(CYCLES_PER_MS + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYCLES_PER_MS - 1);

  logic [CYC_W-1:0] cycCount_reg;
  logic [sbr_pkg::PARAM_W-1:0] msCount_reg;
  logic [sbr_pkg::PARAM_W-1:0] delay_reg;
  logic running_reg;
  wire msTick;
  wire reached;

  assign msTick = (cycCount_reg == CYC_LAST);
  assign reached = (msCount_reg >= delay_reg);
  assign tmr.expired = running_reg && reached;

  // counting stops once reached, so the count cannot wrap past the delay
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cycCount_reg <= '0;
      msCount_reg <= '0;
      delay_reg <= '0;
      running_reg <= 1'b0;
    end
    else if (tmr.start)
    begin
      cycCount_reg <= '0;
      msCount_reg <= '0;
      delay_reg <= tmr.delayMs;
      running_reg <= 1'b1;
    end
    else if (running_reg && !reached)
    begin
      if (msTick)
      begin
        cycCount_reg <= '0;
        msCount_reg <= msCount_reg + 16'h0001;
      end
      else
      begin
        cycCount_reg <= cycCount_reg + CYC_W'(1);
      end
    end
  end
endmodule : sbr_ms_timer
`default_nettype wire

// File: rtl/sbr_brake_sequencer.sv
// brake release sequencer with parameter registers on an avalon-mm slave
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sbr_brake_sequencer #(
  parameter int CYCLES_PER_MS = sbr_pkg::CYCLES_PER_MS
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic servoEnableInput,
  input wire logic [sbr_pkg::PARAM_W-1:0] motorSpeed,
  input wire logic [sbr_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [sbr_pkg::DATA_W-1:0] writedata,
  output logic [sbr_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic brakeReleaseOutput
);
  localparam int PW = sbr_pkg::PARAM_W;
  localparam int DW = sbr_pkg::DATA_W;

  sbr_timer_if tmrIf ();

  logic servoEn;
  logic [PW-1:0] releaseDelay_reg;
  logic [PW-1:0] engageDelay_reg;
  logic [PW-1:0] zeroSpeed_reg;
  logic [PW-1:0] lockCfg_reg;
  logic [PW-1:0] restartPend_reg;
  logic [PW-1:0] restartAct_reg;
  logic [PW-1:0] volatile_reg;
  logic [PW-1:0] refusedCount_reg;
  logic [DW-1:0] readdata_reg;
  logic waitreq_reg;
  logic brake_reg;
  logic brake_next;
  sbr_pkg::sbr_state_type state_reg;
  sbr_pkg::sbr_state_type state_next;
  logic [DW-1:0] rdMux;

  sbr_sync3 servoSync
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .asyncIn(servoEnableInput),
    .syncOut(servoEn)
  );

  sbr_ms_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) delayTimer
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .tmr(tmrIf.timer)
  );

  // address is group in the top bits, index in the low bits
  wire [2:0] group;
  wire [4:0] index;
  wire grpMon;
  wire grpBasic;
  wire grpExt;
  wire grpComm;
  wire grpDiag;
  assign group = address[sbr_pkg::ADDR_W-1:sbr_pkg::GROUP_LSB];
  assign index = address[sbr_pkg::GROUP_LSB-1:0];
  assign grpMon = (group == sbr_pkg::GRP_MONITOR);
  assign grpBasic = (group == sbr_pkg::GRP_BASIC);
  assign grpExt = (group == sbr_pkg::GRP_EXTENSION);
  assign grpComm = (group == sbr_pkg::GRP_COMM);
  assign grpDiag = (group == sbr_pkg::GRP_DIAG);

  wire selStatus;
  wire selRestartAct;
  wire selReleaseDly;
  wire selEngageDly;
  wire selZeroSpeed;
  wire selLockCfg;
  wire selRestartPend;
  wire selVolatile;
  wire selControl;
  wire selSpeed;
  wire selRefused;
  assign selStatus = grpMon && (index == sbr_pkg::IDX_STATUS);
  assign selRestartAct = grpMon && (index == sbr_pkg::IDX_RESTART_ACT);
  assign selReleaseDly = grpBasic && (index == sbr_pkg::IDX_RELEASE_DLY);
  assign selEngageDly = grpBasic && (index == sbr_pkg::IDX_ENGAGE_DLY);
  assign selZeroSpeed = grpBasic && (index == sbr_pkg::IDX_ZERO_SPEED);
  assign selLockCfg = grpExt && (index == sbr_pkg::IDX_LOCK_CFG);
  assign selRestartPend = grpExt && (index == sbr_pkg::IDX_RESTART_PEND);
  assign selVolatile = grpComm && (index == sbr_pkg::IDX_VOLATILE);
  assign selControl = grpDiag && (index == sbr_pkg::IDX_CONTROL);
  assign selSpeed = grpDiag && (index == sbr_pkg::IDX_SPEED);
  assign selRefused = grpDiag && (index == sbr_pkg::IDX_REFUSED);

  // a write lands on the edge where the master sees waitrequest low
  wire wrCommit;
  wire wrData;
  wire roHit;
  wire lockHit;
  wire lockRefused;
  wire roRefused;
  wire restartCmd;
  wire [PW-1:0] wrVal;
  assign wrCommit = write && !waitreq_reg;
  assign wrVal = writedata[PW-1:0];
  assign roHit = selStatus || selRestartAct || selSpeed || selRefused;
  assign lockHit = selLockCfg || selControl;
  assign roRefused = wrCommit && roHit;
  assign lockRefused = wrCommit && lockHit && servoEn;
  assign wrData = wrCommit && !servoEn;
  assign restartCmd = wrData && selControl && writedata[sbr_pkg::CTRL_RESTART_BIT];

  wire belowZero;
  wire speedStopEn;
  assign belowZero = (motorSpeed < zeroSpeed_reg);
  assign speedStopEn = lockCfg_reg[sbr_pkg::LOCK_SPEED_STOP_BIT];

  wire [DW-1:0] statusWord;
  assign statusWord = {{(DW - 8){1'b0}}, state_reg, 1'b0, belowZero, servoEn, brake_reg};

  assign rdMux = selStatus ? statusWord :
                 selRestartAct ? {{(DW - PW){1'b0}}, restartAct_reg} :
                 selReleaseDly ? {{(DW - PW){1'b0}}, releaseDelay_reg} :
                 selEngageDly ? {{(DW - PW){1'b0}}, engageDelay_reg} :
                 selZeroSpeed ? {{(DW - PW){1'b0}}, zeroSpeed_reg} :
                 selLockCfg ? {{(DW - PW){1'b0}}, lockCfg_reg} :
                 selRestartPend ? {{(DW - PW){1'b0}}, restartPend_reg} :
                 selVolatile ? {{(DW - PW){1'b0}}, volatile_reg} :
                 selSpeed ? {{(DW - PW){1'b0}}, motorSpeed} :
                 selRefused ? {{(DW - PW){1'b0}}, refusedCount_reg} :
                 {DW{1'b0}};

  // timer is started on the transitions that open a wait
  assign tmrIf.start = (state_reg == sbr_pkg::ST_ENGAGED && servoEn) ||
                       (state_reg == sbr_pkg::ST_RELEASED && !servoEn);
  assign tmrIf.delayMs = servoEn ? releaseDelay_reg : engageDelay_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sbr_pkg::ST_ENGAGED:
      begin
        if (servoEn)
        begin
          state_next = sbr_pkg::ST_RELEASE_WAIT;
        end
      end
      sbr_pkg::ST_RELEASE_WAIT:
      begin
        if (!servoEn)
        begin
          state_next = sbr_pkg::ST_ENGAGED;
        end
        else if (tmrIf.expired)
        begin
          state_next = sbr_pkg::ST_RELEASED;
        end
      end
      sbr_pkg::ST_RELEASED:
      begin
        if (!servoEn)
        begin
          state_next = sbr_pkg::ST_ENGAGE_WAIT;
        end
      end
      sbr_pkg::ST_ENGAGE_WAIT:
      begin
        if (servoEn)
        begin
          state_next = sbr_pkg::ST_RELEASED;
        end
        else if (tmrIf.expired)
        begin
          state_next = sbr_pkg::ST_ENGAGED;
        end
        else if (speedStopEn && belowZero)
        begin
          state_next = sbr_pkg::ST_ENGAGED;
        end
      end
      default:
      begin
        state_next = sbr_pkg::ST_ENGAGED;
      end
    endcase
    if (restartCmd)
    begin
      state_next = sbr_pkg::ST_ENGAGED;
    end
  end

  // released only in the two states where the motor may turn
  assign brake_next = (state_next == sbr_pkg::ST_RELEASED) ||
                      (state_next == sbr_pkg::ST_ENGAGE_WAIT);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_reg <= sbr_pkg::ST_ENGAGED;
      brake_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      brake_reg <= brake_next;
    end
  end

  // one wait state per access, then a one-cycle answer
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      waitreq_reg <= 1'b1;
      readdata_reg <= '0;
    end
    else if (waitreq_reg && (read || write))
    begin
      waitreq_reg <= 1'b0;
      readdata_reg <= read ? rdMux : '0;
    end
    else
    begin
      waitreq_reg <= 1'b1;
    end
  end

  // delays and threshold are retained over a restart, only rstn reloads their reset values
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      releaseDelay_reg <= sbr_pkg::RST_RELEASE_DLY;
      engageDelay_reg <= sbr_pkg::RST_ENGAGE_DLY;
      zeroSpeed_reg <= sbr_pkg::RST_ZERO_SPEED;
      restartPend_reg <= sbr_pkg::RST_RESTART;
    end
    else if (wrCommit)
    begin
      if (selReleaseDly)
      begin
        releaseDelay_reg <= wrVal;
      end
      if (selEngageDly)
      begin
        engageDelay_reg <= wrVal;
      end
      if (selZeroSpeed)
      begin
        zeroSpeed_reg <= wrVal;
      end
      if (selRestartPend)
      begin
        restartPend_reg <= wrVal;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      lockCfg_reg <= sbr_pkg::RST_LOCK_CFG;
    end
    else if (wrData && selLockCfg)
    begin
      lockCfg_reg <= wrVal;
    end
  end

  // the new value only takes over on a restart
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      restartAct_reg <= sbr_pkg::RST_RESTART;
    end
    else if (restartCmd)
    begin
      restartAct_reg <= restartPend_reg;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      volatile_reg <= sbr_pkg::RST_VOLATILE;
    end
    else if (restartCmd)
    begin
      volatile_reg <= sbr_pkg::RST_VOLATILE;
    end
    else if (wrCommit && selVolatile)
    begin
      volatile_reg <= wrVal;
    end
  end

  // saturating count of refused writes for diagnosis
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      refusedCount_reg <= '0;
    end
    else if ((roRefused || lockRefused) && (refusedCount_reg != {PW{1'b1}}))
    begin
      refusedCount_reg <= refusedCount_reg + 16'h0001;
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitreq_reg;
  assign brakeReleaseOutput = brake_reg;
endmodule : sbr_brake_sequencer
`default_nettype wire

// File: bench/sbr_brake_coil_model.sv
// brake relay coil and holding brake behind the release output
`timescale 1ns/1ps
`default_nettype none
module sbr_brake_coil_model #(
  parameter int PULL_IN_CYCLES = 3
)
(
  input wire logic core_clk,
  input wire logic brakeReleaseOutput,
  output logic shaftFree
);
  int pullCnt = 0;
  initial shaftFree = 1'b0;
  // coil energised lifts the brake after a pull-in time; de-energised drops it at once
  always @(posedge core_clk)
  begin
    if (brakeReleaseOutput !== 1'b1)
    begin
      pullCnt <= 0;
      shaftFree <= 1'b0;
    end
    else if (pullCnt < PULL_IN_CYCLES)
      pullCnt <= pullCnt + 1;
    else
      shaftFree <= 1'b1;
  end
endmodule : sbr_brake_coil_model
`default_nettype wire

// File: bench/sbr_brake_sequencer_chk.sv
// concurrent checks on the ports of the brake release sequencer
`timescale 1ns/1ps
`default_nettype none
module sbr_brake_sequencer_chk
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic servoEnableInput,
  input wire logic [sbr_pkg::PARAM_W-1:0] motorSpeed,
  input wire logic [sbr_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [sbr_pkg::DATA_W-1:0] writedata,
  input wire logic [sbr_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic brakeReleaseOutput
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_RESET_STATE:
    assert property ($rose(rstn) |-> !brakeReleaseOutput && waitrequest)
    else $error("brake or waitrequest wrong after reset");
  AST_ANSWER_NEXT:
    assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered in one cycle");
  AST_ANSWER_ONE:
    assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_UPPER_ZERO:
    assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("readdata upper half not zero");
  AST_UNMAPPED_ZERO:
    assert property (!waitrequest && $past(read) && $past(address[7:5]) > 3'h4
      |-> readdata == 32'h00000000)
    else $error("unmapped group read not zero");
  AST_SPEED_ECHO:
    assert property (!waitrequest && $past(read) && $past(address) == 8'h81
      |-> readdata[15:0] == $past(motorSpeed))
    else $error("speed readback differs");
  AST_RELEASE_AFTER_ON:
    assert property ($rose(brakeReleaseOutput) |-> servoEnableInput && $past(servoEnableInput, 3))
    else $error("brake released without servo enabled");
  AST_ENGAGE_AFTER_OFF:
    assert property ($fell(brakeReleaseOutput) |-> !servoEnableInput && !$past(servoEnableInput, 3))
    else $error("brake engaged while servo enabled");
endmodule : sbr_brake_sequencer_chk
`default_nettype wire

// File: bench/test_servo_brake_release_sequencer.sv
// testbench for the brake release sequencer
`timescale 1ns/1ps
`default_nettype none
module test_servo_brake_release_sequencer;
  localparam int CPM = 10;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic servoEnableInput = 1'b0;
  logic [15:0] motorSpeed = 16'h0064;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic brakeReleaseOutput;
  logic shaftFree;
  logic [31:0] rd;
  int errTotal = 0;
  int totalChecks = 0;
  int cycles = 0;
  int cnt;
  logic [7:0] rstAddr [8] = '{8'h20, 8'h21, 8'h22, 8'h40, 8'h41, 8'h60, 8'h01, 8'h00};
  logic [31:0] rstVal [8] = '{32'h0, 32'h0, 32'ha, 32'h1, 32'h0, 32'h0, 32'h0, 32'h10};

  sbr_brake_sequencer #(.CYCLES_PER_MS(CPM)) dut (.core_clk(core_clk), .rstn(rstn),
    .servoEnableInput(servoEnableInput), .motorSpeed(motorSpeed), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .brakeReleaseOutput(brakeReleaseOutput));
  sbr_brake_coil_model coil (.core_clk(core_clk), .brakeReleaseOutput(brakeReleaseOutput),
    .shaftFree(shaftFree));

  initial forever #5 core_clk = ~core_clk;

  task summarize;
  begin
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask : summarize

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errTotal = errTotal + 1;
      summarize();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    totalChecks = totalChecks + 1;
    if (seen !== exp)
    begin
      errTotal = errTotal + 1;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask : check

  // the request is held until the edge where waitrequest is seen low
  task access(input logic isWrite, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= isWrite;
    read <= !isWrite;
    do
    begin
      @(posedge core_clk);
      n = n + 1;
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    check("wait states", n, 32'h2);
  end
  endtask : access

  task avRead(input logic [7:0] a, input logic [31:0] exp);
  begin
    access(1'b0, a, 32'h0);
    check("readdata", rd, exp);
  end
  endtask : avRead

  // counts cycles until the brake output reaches the wanted level
  task waitBrake(input logic lvl);
  begin
    cnt = 0;
    do
    begin
      @(posedge core_clk);
      cnt = cnt + 1;
    end
    while (brakeReleaseOutput !== lvl && cnt < 300);
  end
  endtask : waitBrake

  initial
  begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    check("brake after reset", {31'h0, brakeReleaseOutput}, 32'h0);
    for (int i = 0; i < 8; i++)
      avRead(rstAddr[i], rstVal[i]);
    avRead(8'ha0, 32'h0);
    access(1'b1, 8'h20, 32'h3);
    access(1'b1, 8'h21, 32'h5);
    avRead(8'h20, 32'h3);
    avRead(8'h21, 32'h5);
    access(1'b1, 8'h00, 32'hff);
    access(1'b1, 8'h81, 32'h7);
    access(1'b1, 8'he0, 32'h7);
    avRead(8'h00, 32'h10);
    avRead(8'h81, 32'h64);
    avRead(8'h82, 32'h2);
    @(posedge core_clk);
    servoEnableInput <= 1'b1;
    waitBrake(1'b1);
    check("release delay", {31'h0, cnt >= 3 * CPM && cnt <= 3 * CPM + 8}, 32'h1);
    repeat (6) @(posedge core_clk);
    check("shaft free", {31'h0, shaftFree}, 32'h1);
    avRead(8'h00, 32'h43);
    access(1'b1, 8'h40, 32'h0);
    access(1'b1, 8'h80, 32'h1);
    avRead(8'h40, 32'h1);
    avRead(8'h82, 32'h4);
    @(posedge core_clk);
    servoEnableInput <= 1'b0;
    waitBrake(1'b0);
    check("engage delay", {31'h0, cnt >= 5 * CPM && cnt <= 5 * CPM + 8}, 32'h1);
    @(posedge core_clk);
    servoEnableInput <= 1'b1;
    waitBrake(1'b1);
    servoEnableInput <= 1'b0;
    repeat (9) @(posedge core_clk);
    motorSpeed <= 16'h0009;
    waitBrake(1'b0);
    check("zero speed engage", {31'h0, cnt >= 1 && cnt <= 6}, 32'h1);
    motorSpeed <= 16'h000a;
    avRead(8'h00, 32'h10);
    access(1'b1, 8'h41, 32'h7);
    access(1'b1, 8'h60, 32'h9);
    access(1'b1, 8'h40, 32'h0);
    avRead(8'h40, 32'h0);
    avRead(8'h01, 32'h0);
    avRead(8'h60, 32'h9);
    access(1'b1, 8'h80, 32'h1);
    avRead(8'h01, 32'h7);
    avRead(8'h60, 32'h0);
    avRead(8'h80, 32'h0);
    // early engage now switched off, so a slow motor must wait out the full delay
    motorSpeed <= 16'h0009;
    @(posedge core_clk);
    servoEnableInput <= 1'b1;
    waitBrake(1'b1);
    servoEnableInput <= 1'b0;
    waitBrake(1'b0);
    check("no early engage", {31'h0, cnt >= 5 * CPM && cnt <= 5 * CPM + 8}, 32'h1);
    summarize();
  end
endmodule : test_servo_brake_release_sequencer

bind sbr_brake_sequencer sbr_brake_sequencer_chk chk (.core_clk(core_clk), .rstn(rstn),
  .servoEnableInput(servoEnableInput), .motorSpeed(motorSpeed), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .brakeReleaseOutput(brakeReleaseOutput));
`default_nettype wire
